// >>> design/cam_core.sv
// Contract
// - 16-bit integer unit: add, sub, shift, logic
// - arithmetic is two's complement
// - updates carry, zero, negative, overflow, digit-carry
// - subtract: carry is inverted borrow, digit-carry inverted digit-borrow
// - byte or word width per command
// - operands from registers or memory, results likewise
// - signed 17x17 multiplier for all sign mixes
// - word sign mixes, 5-bit literal, 8x8 unsigned
// - divide 32/16 or 16/16, signed or unsigned
// - quotient to register zero, remainder register one
// - divisor always opb, dividend even-aligned pair
// - one cycle per divisor bit plus one fold cycle (17 in all), both sizes
// - 17x17 multiplier, 40-bit shifter, adder, two accumulators
// - accumulator add, subtract, negate need no operands
// - fractional/integer and sign-mode multiply selection
// - conventional or convergent rounding selection
// - separate clamp enables A, B, memory; mode
// - multiply-subtract from accumulator, writes other back
`timescale 1ns/10ps
`default_nettype none
`include "cam_regs.svh"

module cam_core (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // status
    output logic             busy
);
    import cam_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0]  core_control_word;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [15:0] opc;
    logic [7:0]  cmd;
    logic [7:0]  status_word;
    logic [31:0] result;
    logic [39:0] first_accumulator;
    logic [39:0] second_accumulator;
    logic [15:0] quotient_dest_reg;
    logic [15:0] remainder_dest_reg;
    cam_state_e  state;

    logic wr_en;
    logic go;
    assign wr_en = psel && penable && pwrite;
    assign go    = wr_en && paddr == `CAM_OFF_CMD && state == CAM_IDLE;

    cam_op_e   op;
    cam_sign_e multiply_sign_select;
    logic      byte_mode;
    logic      rounding_select;
    logic      first_acc_clamp_enable;
    logic      second_acc_clamp_enable;
    logic      memory_write_clamp_enable;
    logic      clamp_mode_select;
    logic      int_mode;
    assign op                        = cam_op_e'(pwdata[`CAM_CMD_OP_LO +: 5]);
    assign byte_mode                 = pwdata[`CAM_CMD_BYTE];
    assign multiply_sign_select      = cam_sign_e'(core_control_word[`CAM_CTRL_US_LO +: 2]);
    assign int_mode                  = core_control_word[`CAM_CTRL_INT];
    assign rounding_select           = core_control_word[`CAM_CTRL_RND];
    assign first_acc_clamp_enable    = core_control_word[`CAM_CTRL_FIRST_ACC_CLAMP_ENABLE];
    assign second_acc_clamp_enable   = core_control_word[`CAM_CTRL_SECOND_ACC_CLAMP_ENABLE];
    assign memory_write_clamp_enable = core_control_word[`CAM_CTRL_MEMORY_WRITE_CLAMP_ENABLE];
    assign clamp_mode_select         = core_control_word[`CAM_CTRL_CLAMP_MODE_SELECT];

    // ****************************************************************
    // integer unit
    // ****************************************************************
    logic [16:0] alu_sum;
    logic [15:0] alu_res;
    logic [4:0]  nib;
    logic        alu_c;
    logic        alu_ov;
    logic        alu_n;
    logic        alu_z;
    logic        alu_dc;
    logic        is_sub;
    logic [3:0]  shamt;
    always_comb begin
        is_sub  = op == CAM_OP_SUB;
        shamt   = opb[3:0];
        alu_sum = 17'h00000;
        nib     = 5'h00;
        alu_res = 16'h0000;
        alu_c   = status_word[`CAM_SR_C];
        alu_ov  = 1'b0;
        alu_dc  = status_word[`CAM_SR_DC];
        case (op)
            CAM_OP_ADD, CAM_OP_SUB: begin
                // two's complement: subtract adds inverse plus one; carry=1 means no borrow
                alu_sum = {1'b0, opa} + {1'b0, (is_sub ? ~opb : opb)} + {16'h0000, is_sub};
                nib     = {1'b0, opa[3:0]} + {1'b0, (is_sub ? ~opb[3:0] : opb[3:0])} + {4'h0, is_sub};
                alu_res = alu_sum[15:0];
                alu_dc  = nib[4];
                if (byte_mode) begin
                    alu_c  = alu_sum[8] ^ opa[8] ^ (is_sub ? ~opb[8] : opb[8]);
                    alu_ov = (opa[7] ~^ (is_sub ? ~opb[7] : opb[7])) && (alu_res[7] ^ opa[7]);
                end else begin
                    alu_c  = alu_sum[16];
                    alu_ov = (opa[15] ~^ (is_sub ? ~opb[15] : opb[15])) && (alu_res[15] ^ opa[15]);
                end
            end
            CAM_OP_AND: alu_res = opa & opb;
            CAM_OP_IOR: alu_res = opa | opb;
            CAM_OP_XOR: alu_res = opa ^ opb;
            CAM_OP_SHL: begin
                alu_res = opa << shamt;
                alu_c   = byte_mode ? opa[7] : opa[15];
            end
            CAM_OP_LSR: begin
                alu_res = byte_mode ? {8'h00, opa[7:0] >> shamt} : opa >> shamt;
                alu_c   = opa[0];
            end
            CAM_OP_ASR: begin
                alu_res = byte_mode ? {8'h00, 8'($signed(opa[7:0]) >>> shamt)}
                                    : 16'($signed(opa) >>> shamt);
                alu_c   = opa[0];
            end
            default: alu_res = 16'h0000;
        endcase
        if (byte_mode) begin
            alu_res = {8'h00, alu_res[7:0]};
        end
        alu_n = byte_mode ? alu_res[7] : alu_res[15];
        alu_z = alu_res == 16'h0000;
    end

    // ****************************************************************
    // 17x17 signed multiplier (shared by integer and dsp paths)
    // ****************************************************************
    logic        ma_sgn;
    logic        mb_sgn;
    logic [15:0] ma;
    logic [15:0] mb;
    logic [33:0] mprod;
    always_comb begin
        ma     = opa;
        mb     = opb;
        ma_sgn = pwdata[`CAM_CMD_SGN];
        mb_sgn = 1'b0;
        case (op)
            CAM_OP_MULLIT: mb = {11'h000, opb[4:0]};
            CAM_OP_MUL8: begin
                ma     = {8'h00, opa[7:0]};
                mb     = {8'h00, opb[7:0]};
                ma_sgn = 1'b0;
            end
            CAM_OP_ED, CAM_OP_DIFF_SQUARE_ACCUMULATE_OP: begin
                ma     = 16'(opa - opb);
                mb     = 16'(opa - opb);
                ma_sgn = 1'b1;
                mb_sgn = 1'b1;
            end
            default: begin
                ma_sgn = multiply_sign_select == CAM_US_SS || multiply_sign_select == CAM_US_SU;
                mb_sgn = multiply_sign_select == CAM_US_SS || multiply_sign_select == CAM_US_US;
            end
        endcase
        // 17th bit carries sign or zero so one signed array serves all mixes
        mprod = 34'($signed({ma_sgn & ma[15], ma}) * $signed({mb_sgn & mb[15], mb}));
    end

    // ****************************************************************
    // dsp engine: 40-bit adder, shifter, rounding, saturation
    // ****************************************************************
    logic [39:0] prod40;
    logic [39:0] acc_t;
    logic [39:0] acc_o;
    logic [40:0] dsum;
    logic [39:0] dsp_raw;
    logic [39:0] dsp_res;
    logic [39:0] shifted;
    logic        tgt_b;
    logic        clamp_en;
    logic        dsp_sat;
    always_comb begin
        tgt_b   = pwdata[`CAM_CMD_ACCSEL];
        acc_t   = tgt_b ? second_accumulator : first_accumulator;
        acc_o   = tgt_b ? first_accumulator : second_accumulator;
        // fractional mode shifts product left one place
        prod40  = int_mode ? {{6{mprod[33]}}, mprod} : {{5{mprod[33]}}, mprod, 1'b0};
        shifted = opb[15] ? 40'(acc_t >> (~opb[5:0] + 6'h01)) : 40'(acc_t << opb[5:0]);
        case (op)
            CAM_OP_CLR:  dsum = 41'h0;
            CAM_OP_MPY,
            CAM_OP_ED:   dsum = {prod40[39], prod40};
            CAM_OP_MPYN: dsum = 41'h0 - {prod40[39], prod40};
            CAM_OP_MAC,
            CAM_OP_DIFF_SQUARE_ACCUMULATE_OP: dsum = {acc_t[39], acc_t} + {prod40[39], prod40};
            CAM_OP_MSC:  dsum = {acc_t[39], acc_t} - {prod40[39], prod40};
            CAM_OP_AADD: dsum = {acc_t[39], acc_t} + {acc_o[39], acc_o};
            CAM_OP_ASUB: dsum = {acc_t[39], acc_t} - {acc_o[39], acc_o};
            CAM_OP_ANEG: dsum = 41'h0 - {acc_t[39], acc_t};
            CAM_OP_SFTAC: dsum = {shifted[39], shifted};
            default:     dsum = {acc_t[39], acc_t};
        endcase
        clamp_en = tgt_b ? second_acc_clamp_enable : first_acc_clamp_enable;
        dsp_raw  = dsum[39:0];
        dsp_sat  = 1'b0;
        dsp_res  = dsp_raw;
        if (clamp_en) begin
            if (clamp_mode_select) begin
                // 9.31 mode: clamp on 40-bit overflow
                if (dsum[40] != dsum[39]) begin
                    dsp_sat = 1'b1;
                    dsp_res = dsum[40] ? 40'h8000000000 : 40'h7fffffffff;
                end
            end else if (dsum[40:31] != {10{dsum[40]}}) begin
                // 1.31 mode: clamp to 32-bit range
                dsp_sat = 1'b1;
                dsp_res = dsum[40] ? 40'hff80000000 : 40'h007fffffff;
            end
        end
    end

    // rounded and clamped word for write-back
    logic [39:0] rnd_acc;
    logic [15:0] wb_word;
    always_comb begin
        rnd_acc = acc_o;
        // convergent rounding breaks ties toward even
        if (acc_o[15] && (acc_o[14:0] != 15'h0000 || !rounding_select || acc_o[16])) begin
            rnd_acc = acc_o + 40'h0000010000;
        end
        wb_word = rnd_acc[31:16];
        if (memory_write_clamp_enable && rnd_acc[39:31] != {9{rnd_acc[39]}}) begin
            wb_word = rnd_acc[39] ? 16'h8000 : 16'h7fff;
        end
    end

    // ****************************************************************
    // iterative divider, one step per divisor bit
    // ****************************************************************
    logic [31:0] div_num;
    logic [16:0] div_rem;
    logic [15:0] div_den;
    logic [4:0]  div_cnt;
    logic        div_qneg;
    logic        div_rneg;
    logic [16:0] trial;
    logic        div_zero;
    // dividend taken from even pair: odd register is upper half, 16-bit form sign/zero extends
    logic [31:0] ld_num;
    logic [15:0] ld_den;
    logic        ld_sgn;
    always_comb begin
        ld_sgn   = pwdata[`CAM_CMD_SGN];
        ld_num   = op == CAM_OP_DIV32 ? {opc, opa} : {{16{ld_sgn & opa[15]}}, opa};
        ld_den   = opb;
        div_zero = ld_den == 16'h0000;
        trial    = {div_rem[15:0], div_num[31]} - {1'b0, div_den};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= CAM_IDLE;
            div_num  <= 32'h0;
            div_rem  <= 17'h0;
            div_den  <= 16'h0;
            div_cnt  <= 5'h0;
            div_qneg <= 1'b0;
            div_rneg <= 1'b0;
        end else begin
            case (state)
                CAM_IDLE: begin
                    if (go && (op == CAM_OP_DIV32 || op == CAM_OP_DIV16) && !div_zero) begin
                        state    <= CAM_DIV;
                        div_num  <= (ld_sgn && ld_num[31]) ? 32'(-ld_num) : ld_num;
                        div_den  <= (ld_sgn && ld_den[15]) ? 16'(-ld_den) : ld_den;
                        div_rem  <= 17'h0;
                        div_cnt  <= `CAM_DIV_STEPS;
                        div_qneg <= ld_sgn && (ld_num[31] ^ ld_den[15]);
                        div_rneg <= ld_sgn && ld_num[31];
                    end
                end
                CAM_DIV: begin
                    // first step folds the high half in, so both sizes take the same count
                    if (div_cnt == `CAM_DIV_STEPS) begin
                        div_rem <= {1'b0, div_num[31:16] % div_den};
                        div_num <= {div_num[15:0], 16'h0000};
                        div_cnt <= div_cnt - 5'h01;
                    end else begin
                        if (!trial[16]) begin
                            div_rem <= trial;
                        end else begin
                            div_rem <= {div_rem[15:0], div_num[31]};
                        end
                        div_num <= {div_num[30:0], !trial[16]};
                        div_cnt <= div_cnt - 5'h01;
                        if (div_cnt == 5'h00) begin
                            state <= CAM_IDLE;
                        end
                    end
                end
                default: state <= CAM_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // results, accumulators, status
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_control_word <= `CAM_CTRL_RESET;
            opa               <= 16'h0000;
            opb               <= 16'h0000;
            opc               <= 16'h0000;
            cmd               <= 8'h00;
        end else if (wr_en && state == CAM_IDLE) begin
            case (paddr)
                `CAM_OFF_CTRL: core_control_word <= pwdata[7:0];
                `CAM_OFF_OPA:  opa               <= pwdata[15:0];
                `CAM_OFF_OPB:  opb               <= pwdata[15:0];
                `CAM_OFF_OPC:  opc               <= pwdata[15:0];
                `CAM_OFF_CMD:  cmd               <= pwdata[7:0];
                default:       ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_word        <= 8'h00;
            result             <= 32'h0;
            first_accumulator  <= 40'h0;
            second_accumulator <= 40'h0;
            quotient_dest_reg  <= 16'h0000;
            remainder_dest_reg <= 16'h0000;
        end else if (go) begin
            case (op)
                CAM_OP_ADD, CAM_OP_SUB, CAM_OP_AND, CAM_OP_IOR,
                CAM_OP_XOR, CAM_OP_SHL, CAM_OP_LSR, CAM_OP_ASR: begin
                    result                    <= {16'h0000, alu_res};
                    status_word[`CAM_SR_C]    <= alu_c;
                    status_word[`CAM_SR_Z]    <= alu_z;
                    status_word[`CAM_SR_N]    <= alu_n;
                    status_word[`CAM_SR_OV]   <= alu_ov;
                    status_word[`CAM_SR_DC]   <= alu_dc;
                end
                CAM_OP_MUL, CAM_OP_MULLIT, CAM_OP_MUL8: result <= mprod[31:0];
                CAM_OP_DIV32, CAM_OP_DIV16: begin
                    status_word[`CAM_SR_DIVERR] <= div_zero;
                    status_word[`CAM_SR_BUSY]   <= !div_zero;
                end
                CAM_OP_SACWR: result <= {16'h0000, wb_word};
                default: begin
                    if (tgt_b) begin
                        second_accumulator <= dsp_res;
                    end else begin
                        first_accumulator  <= dsp_res;
                    end
                    status_word[`CAM_SR_SATFLAG] <= dsp_sat;
                    // write-back of the other accumulator for clr, mac and msc
                    if (op == CAM_OP_MSC || op == CAM_OP_MAC || op == CAM_OP_CLR) begin
                        result <= {16'h0000, wb_word};
                    end
                end
            endcase
        end else if (state == CAM_DIV && div_cnt == 5'h00) begin
            if (!trial[16]) begin
                remainder_dest_reg <= div_rneg ? 16'(-trial[15:0]) : trial[15:0];
                quotient_dest_reg  <= div_qneg ? 16'(-{div_num[14:0], 1'b1}) : {div_num[14:0], 1'b1};
            end else begin
                remainder_dest_reg <= div_rneg ? 16'(-{div_rem[14:0], div_num[31]}) : {div_rem[14:0], div_num[31]};
                quotient_dest_reg  <= div_qneg ? 16'(-{div_num[14:0], 1'b0}) : {div_num[14:0], 1'b0};
            end
            status_word[`CAM_SR_BUSY] <= 1'b0;
        end
    end

    // ****************************************************************
    // apb read path and outputs
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            busy    <= 1'b0;
        end else begin
            // falls with the edge that writes quotient and remainder
            busy    <= state == CAM_DIV && div_cnt != 5'h00
                       || go && (op == CAM_OP_DIV32 || op == CAM_OP_DIV16) && !div_zero;
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `CAM_OFF_CTRL:    prdata <= {24'h0, core_control_word};
                    `CAM_OFF_OPA:     prdata <= {16'h0, opa};
                    `CAM_OFF_OPB:     prdata <= {16'h0, opb};
                    `CAM_OFF_OPC:     prdata <= {16'h0, opc};
                    `CAM_OFF_CMD:     prdata <= {24'h0, cmd};
                    `CAM_OFF_STATUS:  prdata <= {24'h0, status_word};
                    `CAM_OFF_RESLO:   prdata <= {16'h0, result[15:0]};
                    `CAM_OFF_RESHI:   prdata <= {16'h0, result[31:16]};
                    `CAM_OFF_FIRST_ACCUMULATOR_LO: prdata <= first_accumulator[31:0];
                    `CAM_OFF_FIRST_ACCUMULATOR_HI: prdata <= {24'h0, first_accumulator[39:32]};
                    `CAM_OFF_SECOND_ACCUMULATOR_LO: prdata <= second_accumulator[31:0];
                    `CAM_OFF_SECOND_ACCUMULATOR_HI: prdata <= {24'h0, second_accumulator[39:32]};
                    `CAM_OFF_QUOT:    prdata <= {16'h0, quotient_dest_reg};
                    `CAM_OFF_REM:     prdata <= {16'h0, remainder_dest_reg};
                    default:          prdata <= 32'h0;
                endcase
            end
            if (psel && !penable && !(paddr[1:0] == 2'b00 && paddr <= `CAM_OFF_REM)) begin
                pslverr <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// >>> design/cam_regs.svh
`ifndef CAM_REGS_SVH
`define CAM_REGS_SVH
// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define CAM_OFF_CTRL     12'h000
`define CAM_OFF_OPA      12'h004
`define CAM_OFF_OPB      12'h008
`define CAM_OFF_OPC      12'h00c
`define CAM_OFF_CMD      12'h010
`define CAM_OFF_STATUS   12'h014
`define CAM_OFF_RESLO    12'h018
`define CAM_OFF_RESHI    12'h01c
`define CAM_OFF_FIRST_ACCUMULATOR_LO  12'h020
`define CAM_OFF_FIRST_ACCUMULATOR_HI  12'h024
`define CAM_OFF_SECOND_ACCUMULATOR_LO  12'h028
`define CAM_OFF_SECOND_ACCUMULATOR_HI  12'h02c
`define CAM_OFF_QUOT     12'h030
`define CAM_OFF_REM      12'h034
// ****************************************************************
// core control word fields and reset
// ****************************************************************
`define CAM_CTRL_INT     0
`define CAM_CTRL_US_LO   1
`define CAM_CTRL_RND     3
`define CAM_CTRL_FIRST_ACC_CLAMP_ENABLE    4
`define CAM_CTRL_SECOND_ACC_CLAMP_ENABLE    5
`define CAM_CTRL_MEMORY_WRITE_CLAMP_ENABLE   6
`define CAM_CTRL_CLAMP_MODE_SELECT  7
`define CAM_CTRL_RESET   8'h41
// ****************************************************************
// command word fields
// ****************************************************************
`define CAM_CMD_OP_LO    0
`define CAM_CMD_BYTE     5
`define CAM_CMD_SGN      6
`define CAM_CMD_ACCSEL   7
// ****************************************************************
// status word flag positions
// ****************************************************************
`define CAM_SR_C         0
`define CAM_SR_Z         1
`define CAM_SR_OV        2
`define CAM_SR_N         3
`define CAM_SR_DC        4
`define CAM_SR_BUSY      5
`define CAM_SR_DIVERR    6
`define CAM_SR_SATFLAG   7
// ****************************************************************
// divider iteration count
// ****************************************************************
`define CAM_DIV_STEPS    5'h10
`endif

// >>> design/cam_pkg.sv
package cam_pkg;
    typedef enum logic [4:0] {
        CAM_OP_ADD, CAM_OP_SUB, CAM_OP_AND, CAM_OP_IOR, CAM_OP_XOR,
        CAM_OP_SHL, CAM_OP_LSR, CAM_OP_ASR,
        CAM_OP_MUL, CAM_OP_MULLIT, CAM_OP_MUL8,
        CAM_OP_DIV32, CAM_OP_DIV16,
        CAM_OP_CLR, CAM_OP_MPY, CAM_OP_MPYN, CAM_OP_MAC, CAM_OP_MSC,
        CAM_OP_ED, CAM_OP_DIFF_SQUARE_ACCUMULATE_OP, CAM_OP_AADD, CAM_OP_ASUB, CAM_OP_ANEG,
        CAM_OP_SFTAC, CAM_OP_SACWR
    } cam_op_e;
    typedef enum logic [1:0] {
        CAM_US_SS, CAM_US_UU, CAM_US_SU, CAM_US_US
    } cam_sign_e;
    typedef enum {
        CAM_IDLE, CAM_DIV
    } cam_state_e;
endpackage

// >>> sim/cam_core_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cam_core_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready) else $error("no answer");
    a_ready_once: assert property (pready |=> !pready) else $error("long answer");
    a_ready_qual: assert property (pready |-> psel && penable) else $error("stray answer");
    a_busy_hold: assert property ($rose(busy) |-> busy[*8]) else $error("short divide");
    a_busy_end: assert property ($rose(busy) |-> ##16 busy ##1 !busy) else $error("divide length");
    a_err_unmapped: assert property (pready && paddr > 12'h034 |-> pslverr) else $error("no error");
    a_err_mapped: assert property (pready && paddr <= 12'h034 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("bad error");
    a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error data");
endmodule
bind cam_core cam_core_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy));
`default_nettype wire

// >>> sim/cam_host.sv
`timescale 1ns/10ps
`default_nettype none
module cam_host (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // one apb transfer, held until pready is sampled
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// >>> sim/core_arith_mul_div_dsp_bench.sv
`timescale 1ns/10ps
`default_nettype none
module core_arith_mul_div_dsp_bench;
    import cam_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          failures, checks_done;
    cam_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
    cam_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        host.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rc(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        host.xfer(1'b0, a, 32'h0, r, e);
        chk(n, r & m, x);
    endtask
    // flags: b2 target b, b1 signed, b0 byte
    task automatic op(input cam_op_e o, input logic [2:0] f, input logic [31:0] a, input logic [31:0] b);
        wr(12'h004, a);
        wr(12'h008, b);
        wr(12'h010, {24'h0, f, o});
    endtask
    task automatic t_alu;
        rc("ctrl", 12'h000, 32'hff, 32'h41);
        op(CAM_OP_ADD, 3'b000, 32'h7fff, 32'h1);
        rc("add", 12'h018, 32'hffff, 32'h8000);
        rc("add_sr", 12'h014, 32'h1f, 32'h1c);
        op(CAM_OP_SUB, 3'b000, 32'h0, 32'h1);
        rc("sub_sr", 12'h014, 32'h1f, 32'h08);
        op(CAM_OP_ADD, 3'b001, 32'hff, 32'h1);
        rc("byte", 12'h018, 32'hff, 32'h0);
        rc("byte_sr", 12'h014, 32'h1f, 32'h13);
        op(CAM_OP_MUL8, 3'b000, 32'hff, 32'hff);
        rc("mul8", 12'h018, 32'hffff, 32'hfe01);
        op(CAM_OP_ASR, 3'b000, 32'h8000, 32'h4);
        rc("asr", 12'h018, 32'hffff, 32'hf800);
    endtask
    task automatic t_div(input cam_op_e o, input logic [2:0] f, input logic [31:0] hi, input logic [31:0] a,
                         input logic [31:0] b, input logic [31:0] q, input logic [31:0] r);
        wr(12'h00c, hi);
        op(o, f, a, b);
        repeat (18) @(posedge pclk);
        chk("busy", {31'h0, busy}, 32'h0);
        rc("quot", 12'h030, 32'hffff, q);
        rc("rem", 12'h034, 32'hffff, r);
    endtask
    task automatic t_dsp;
        logic [31:0] r;
        logic        e;
        op(CAM_OP_MPY, 3'b000, 32'h3, 32'hfffe);
        rc("mpy_lo", 12'h020, 32'hffffffff, 32'hfffffffa);
        rc("mpy_hi", 12'h024, 32'hff, 32'hff);
        op(CAM_OP_ANEG, 3'b000, 32'h0, 32'h0);
        rc("neg", 12'h020, 32'hffffffff, 32'h6);
        host.xfer(1'b0, 12'h038, 32'h0, r, e);
        chk("unmapped", {31'h0, e}, 32'h1);
        chk("unmapped_data", r, 32'h0);
        wr(12'h000, 32'h47);
        op(CAM_OP_MUL, 3'b000, 32'hffff, 32'h8000);
        rc("mul_us", 12'h01c, 32'hffff, 32'h8000);
        op(CAM_OP_MPY, 3'b000, 32'hffff, 32'h3);
        rc("mpy_us", 12'h020, 32'hffffffff, 32'h2fffd);
        op(CAM_OP_MPY, 3'b100, 32'h8000, 32'h1);
        op(CAM_OP_MSC, 3'b000, 32'h2, 32'h3);
        rc("msc", 12'h020, 32'hffffffff, 32'h2fff7);
        rc("round", 12'h018, 32'hffff, 32'h1);
        op(CAM_OP_DIFF_SQUARE_ACCUMULATE_OP, 3'b100, 32'h5, 32'h2);
        rc("diff_square_accumulate_op", 12'h028, 32'hffffffff, 32'h8009);
        wr(12'h000, 32'h57);
        op(CAM_OP_MAC, 3'b000, 32'hffff, 32'h7fff);
        rc("sat", 12'h020, 32'hffffffff, 32'h7fffffff);
        rc("sat_sr", 12'h014, 32'h80, 32'h80);
    endtask
    task automatic end_of_test;
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge pclk);
        failures++;
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_alu();
        t_div(CAM_OP_DIV16, 3'b000, 32'h0, 32'h64, 32'h7, 32'h0e, 32'h2);
        t_div(CAM_OP_DIV16, 3'b010, 32'hffff, 32'hff9c, 32'h7, 32'hfff2, 32'hfffe);
        t_div(CAM_OP_DIV32, 3'b000, 32'h1, 32'h0, 32'h2, 32'h8000, 32'h0);
        wr(12'h00c, 32'h0);
        op(CAM_OP_DIV16, 3'b000, 32'h5, 32'h0);
        repeat (18) @(posedge pclk);
        rc("div_zero", 12'h014, 32'h40, 32'h40);
        t_dsp();
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rc("ctrl_reset", 12'h000, 32'hff, 32'h41);
        end_of_test();
    end
endmodule
`default_nettype wire
